/* File: verif/psd_adc_model.sv */
// psd_adc_model.sv: behavioural battery converter answering the detector's start pulses
// assumes one system clock; latency and result are set by the bench
`timescale 1ns/100ps
`default_nettype none
module psd_adc_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // request and setup
    input wire logic i_start,
    input wire logic [9:0] i_value,
    input wire logic [3:0] i_lat,
    // answer
    output logic o_done,
    output logic [9:0] o_data
);
    int cnt;
    // data only valid with done; it toggles otherwise so a stale word is never mistaken for a result
    always_ff @(posedge i_clk) begin
        o_done <= 1'b0;
        o_data <= ~o_data;
        if (i_rst) begin
            cnt <= 0;
            o_data <= 10'h000;
        end else if (cnt == 1) begin
            o_done <= 1'b1;
            o_data <= i_value;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (i_start) begin
            cnt <= int'(i_lat) + 1;
        end
    end
endmodule : psd_adc_model
`default_nettype wire

/* File: verif/psd_top_tb.sv */
// psd_top_tb.sv: self-checking bench of the source detector over apb
// assumes debounce shortened to 20 cycles and the converter model beside it
`timescale 1ns/100ps
`default_nettype none
`include "psd_cfg.svh"
module psd_top_tb;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] exp;
        logic err;
    } psd_row_t;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic id_high, vbat_ok, sys_ok, usb_ok, adp_ok, adc_start, adc_done;
    logic link_oe, to_host, from_host, batt_pull, sys_valid, low_bat, irq, cold_off;
    logic [9:0] adc_data, adc_value;
    logic [3:0] adc_lat;
    wire line_lvl;
    int err_total = 0;
    int checks = 0;
    psd_row_t rows [9] = '{
        '{1'b0, `PSD_OFF_CTRL, 32'h0, 32'h3, 1'b0},
        '{1'b0, `PSD_OFF_THR_BAT, 32'h0, 32'h111, 1'b0},
        '{1'b0, `PSD_OFF_THR_DC, 32'h0, 32'h1c4, 1'b0},
        '{1'b1, `PSD_OFF_THR_SDP, 32'h2aa, 32'h0, 1'b0},
        '{1'b0, `PSD_OFF_THR_SDP, 32'h0, 32'h2aa, 1'b0},
        '{1'b1, `PSD_OFF_THR_DCP, 32'hffffffff, 32'h0, 1'b0},
        '{1'b0, `PSD_OFF_THR_DCP, 32'h0, 32'h3ff, 1'b0},
        '{1'b0, 12'h024, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h030, 32'h5, 32'h0, 1'b1}};

    // open-drain battery line with pull-up
    assign line_lvl = !(link_oe || batt_pull);

    psd_top #(.DEB_CYC(20)) i_psd_top (
        .I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_ID_HIGH(id_high), .I_VBAT_OK(vbat_ok), .I_SYS_OK(sys_ok), .I_USB_OK(usb_ok), .I_ADP_OK(adp_ok),
        .I_OTP_THR_BAT(10'h111), .I_OTP_THR_SDP(10'h155), .I_OTP_THR_DCP(10'h1aa), .I_OTP_THR_DC(10'h1c4),
        .O_ADC_START(adc_start), .I_ADC_DONE(adc_done), .I_ADC_DATA(adc_data),
        .I_LINK_LINE_IN(line_lvl), .I_LINK_FROM_HOST(from_host), .O_LINK_LINE_OE(link_oe),
        .O_LINK_TO_HOST(to_host), .O_SYS_VALID(sys_valid), .O_LOW_BATTERY(low_bat), .O_IRQ(irq),
        .O_COLD_OFF(cold_off));

    psd_adc_model i_psd_adc_model (.i_clk(clk), .i_rst(rst), .i_start(adc_start), .i_value(adc_value),
        .i_lat(adc_lat), .o_done(adc_done), .o_data(adc_data));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // one apb transfer; never assumes the wait count, only a bench limit
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 1'b1, pready);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // move one source comparator, check status timing and both flag levels, then clear
    task automatic src(input int b, input logic lvl, input logic db);
        @(posedge clk);
        if (b == 1) usb_ok <= lvl;
        else adp_ok <= lvl;
        if (db) begin
            step(10);
            apb(1'b0, `PSD_OFF_STAT, 32'h0);
            chk("early", !lvl, rd[b]);
            step(40);
        end else begin
            step(3);
        end
        apb(1'b0, `PSD_OFF_STAT, 32'h0);
        chk("status", lvl, rd[b]);
        apb(1'b0, `PSD_OFF_IRQ2, 32'h0);
        chk("flag", 1'b1, rd[b]);
        apb(1'b0, `PSD_OFF_IRQ1, 32'h0);
        chk("summary", 1'b1, rd[0]);
        chk("irq", 1'b1, irq);
        apb(1'b1, `PSD_OFF_IRQ2, 32'hf);
        step(2);
        chk("irq clear", 1'b0, irq);
    endtask : src

    task automatic finish_test;
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    // watchdog: the run needs about a thousand cycles
    initial begin
        step(20000);
        err_total++;
        $display("[ERR] watchdog exp done got hang");
        finish_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {id_high, sys_ok, usb_ok, adp_ok, batt_pull} = '0;
        {rst, vbat_ok, from_host} = 3'b111;
        adc_value = 10'h180;
        adc_lat = 4'h2;
        step(10);
        rst <= 1'b0;
        step(1);
        chk("to host", 1'b1, to_host);
        chk("cold", 1'b0, cold_off);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("slverr", rows[i].err, err);
            if (!rows[i].w) chk("rdata", rows[i].exp, rd);
        end
        step(40);
        apb(1'b1, `PSD_OFF_IRQ2, 32'hf);
        src(1, 1'b1, 1'b1);
        src(1, 1'b0, 1'b1);
        src(2, 1'b1, 1'b1);
        src(2, 1'b0, 1'b1);
        // bounce restarts the count
        apb(1'b1, `PSD_OFF_CTRL, 32'h3);
        usb_ok <= 1'b1;
        step(15);
        usb_ok <= 1'b0;
        step(3);
        usb_ok <= 1'b1;
        step(15);
        apb(1'b0, `PSD_OFF_STAT, 32'h0);
        chk("bounce", 1'b0, rd[1]);
        usb_ok <= 1'b0;
        step(40);
        // rail valid
        sys_ok <= 1'b1;
        step(12);
        chk("rail early", 1'b0, sys_valid);
        step(20);
        chk("rail", 1'b1, sys_valid);
        apb(1'b0, `PSD_OFF_IRQ2, 32'h0);
        chk("rail flag", 1'b1, rd[3]);
        // debounce off, slow converter, adapter threshold above reading
        apb(1'b1, `PSD_OFF_CTRL, 32'h0);
        src(1, 1'b1, 1'b0);
        src(1, 1'b0, 1'b0);
        adc_lat <= 4'hc;
        apb(1'b1, `PSD_OFF_THR_DC, 32'h200);
        src(2, 1'b1, 1'b0);
        step(40);
        chk("low adapter", 1'b1, low_bat);
        src(2, 1'b0, 1'b0);
        step(40);
        chk("low battery only", 1'b0, low_bat);
        apb(1'b0, `PSD_OFF_ADC, 32'h0);
        chk("adc", 32'h180, rd);
        // removal by battery voltage, interrupt only
        apb(1'b1, `PSD_OFF_CTRL, 32'h4);
        vbat_ok <= 1'b0;
        step(50);
        apb(1'b0, `PSD_OFF_STAT, 32'h0);
        chk("vbat removal", 1'b0, rd[0]);
        vbat_ok <= 1'b1;
        step(50);
        // removal by identity line, interrupt only
        apb(1'b1, `PSD_OFF_CTRL, 32'hc);
        apb(1'b1, `PSD_OFF_IRQ2, 32'hf);
        id_high <= 1'b1;
        step(8);
        apb(1'b0, `PSD_OFF_STAT, 32'h0);
        chk("removal early", 1'b1, rd[0]);
        step(40);
        apb(1'b0, `PSD_OFF_STAT, 32'h0);
        chk("id removal", 1'b0, rd[0]);
        apb(1'b0, `PSD_OFF_IRQ2, 32'h0);
        chk("removal flag", 1'b1, rd[0]);
        chk("no cold", 1'b0, cold_off);
        id_high <= 1'b0;
        step(50);
        // link on: pass-through both ways, removal masked
        apb(1'b1, `PSD_OFF_CTRL, 32'h3c);
        batt_pull <= 1'b1;
        step(6);
        chk("line to host", 1'b0, to_host);
        batt_pull <= 1'b0;
        from_host <= 1'b0;
        step(6);
        chk("line drive", 1'b1, link_oe);
        from_host <= 1'b1;
        id_high <= 1'b1;
        step(50);
        apb(1'b0, `PSD_OFF_STAT, 32'h0);
        chk("link hold", 1'b1, rd[0]);
        chk("link cold", 1'b0, cold_off);
        // link off with cold off armed
        apb(1'b1, `PSD_OFF_CTRL, 32'h1c);
        step(50);
        chk("cold off", 1'b1, cold_off);
        finish_test();
    end
endmodule : psd_top_tb
`default_nettype wire

/* File: verilog/psd_cfg.svh */
// psd_cfg.svh: offsets, field positions, reset values and timing counts of the source detector
// assumes inclusion by bare name from the design file and its package
`ifndef PSD_CFG_SVH
`define PSD_CFG_SVH
// timing
`define PSD_CLK_MHZ 100
`define PSD_DEB_MS 100
`define PSD_DEB_CYC (`PSD_DEB_MS * 1000 * `PSD_CLK_MHZ)
`define PSD_CNT_W 24
// register byte offsets
`define PSD_OFF_CTRL 12'h000
`define PSD_OFF_STAT 12'h004
`define PSD_OFF_IRQ2 12'h008
`define PSD_OFF_IRQ1 12'h00c
`define PSD_OFF_THR_BAT 12'h010
`define PSD_OFF_THR_SDP 12'h014
`define PSD_OFF_THR_DCP 12'h018
`define PSD_OFF_THR_DC 12'h01c
`define PSD_OFF_ADC 12'h020
// control fields
`define PSD_C_USBDB 0
`define PSD_C_ADPDB 1
`define PSD_C_RMEN 2
`define PSD_C_RMSRC 3
`define PSD_C_COLD 4
`define PSD_C_DBL 5
`define PSD_C_DCP 6
`define PSD_CTRL_RST 7'h03
// status / flag fields
`define PSD_S_BAT 0
`define PSD_S_USB 1
`define PSD_S_ADP 2
`define PSD_S_SYS 3
`define PSD_S_LOW 4
`define PSD_I_BAT 0
`define PSD_I_USB 1
`define PSD_I_ADP 2
`define PSD_I_SYS 3
`define PSD_ADC_W 10
`endif

/* File: verilog/psd_pkg.sv */
// psd_pkg.sv: types of the power source detector
// assumes psd_cfg.svh on the include path
`include "psd_cfg.svh"
package psd_pkg;
    typedef enum logic [1:0] {
        PSD_ADC_IDLE = 2'b00,
        PSD_ADC_REQ = 2'b01,
        PSD_ADC_WAIT = 2'b11
    } psd_adc_t;
    typedef struct packed {
        logic [6:0] ctrl;
        logic [3:0] flags;
        logic src_flag;
        logic [`PSD_ADC_W-1:0] thr_bat;
        logic [`PSD_ADC_W-1:0] thr_sdp;
        logic [`PSD_ADC_W-1:0] thr_dcp;
        logic [`PSD_ADC_W-1:0] thr_dc;
        logic thr_loaded;
        logic [`PSD_ADC_W-1:0] adc_last;
        logic [1:0] sy_host;
        logic [1:0] sy_id;
        logic [1:0] sy_vbat;
        logic [1:0] sy_sys;
        logic [1:0] sy_usb;
        logic [1:0] sy_adp;
        logic [1:0] sy_lnk;
        logic [3:0] st;
        logic [`PSD_CNT_W-1:0] cnt_bat;
        logic [`PSD_CNT_W-1:0] cnt_sys;
        logic [`PSD_CNT_W-1:0] cnt_usb;
        logic [`PSD_CNT_W-1:0] cnt_adp;
        logic id_hold;
        logic low;
        logic irq;
        logic cold;
        logic adc_start;
        psd_adc_t adc_st;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic link_host;
        logic link_oe;
    } psd_state_t;
endpackage : psd_pkg

/* File: verilog/psd_top.sv */
// psd_top.sv: power source detection logic with APB register file
// assumes comparator and pin inputs asynchronous; ADC and OTP on the system clock
//
// Contract
// R1 - identity line high means removal when enabled
// R2 - removal reported after 100ms stable presence
// R3 - removal does cold off or interrupt only
// R4 - link enable kills analog removal sensing
// R5 - entering link holds last presence state
// R6 - link splits identity line into two pins
// R7 - host may enable link from resistance
// R8 - rail valid after 100ms above threshold
// R9 - usb set after 100ms valid, debounce on
// R10 - usb set at once, debounce off
// R11 - usb cleared after 100ms invalid, debounce on
// R12 - usb cleared at once, debounce off
// R13 - usb change sets flag and summary
// R14 - host reads status after source interrupt
// R15 - adapter set: 100ms or at once
// R16 - adapter cleared: 100ms or at once
// R17 - adapter change sets flag and summary
// R18 - detection done starts battery measurement, compare
// R19 - threshold chosen by active source
// R20 - low pin when reading below threshold
// R21 - thresholds default from OTP, software writable
// R22 - every source event raises interrupt
// R23 - source select picks identity or voltage comparator
// R24 - debounce counter restarts on bounce
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "psd_cfg.svh"
module psd_top #(
    parameter int unsigned DEB_CYC = `PSD_DEB_CYC
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // comparators, asynchronous
    input wire logic I_ID_HIGH,
    input wire logic I_VBAT_OK,
    input wire logic I_SYS_OK,
    input wire logic I_USB_OK,
    input wire logic I_ADP_OK,
    // otp defaults, stable after reset
    input wire logic [`PSD_ADC_W-1:0] I_OTP_THR_BAT,
    input wire logic [`PSD_ADC_W-1:0] I_OTP_THR_SDP,
    input wire logic [`PSD_ADC_W-1:0] I_OTP_THR_DCP,
    input wire logic [`PSD_ADC_W-1:0] I_OTP_THR_DC,
    // adc
    output logic O_ADC_START,
    input wire logic I_ADC_DONE,
    input wire logic [`PSD_ADC_W-1:0] I_ADC_DATA,
    // battery link pass-through
    input wire logic I_LINK_LINE_IN,
    input wire logic I_LINK_FROM_HOST,
    output logic O_LINK_LINE_OE,
    output logic O_LINK_TO_HOST,
    // system
    output logic O_SYS_VALID,
    output logic O_LOW_BATTERY,
    output logic O_IRQ,
    output logic O_COLD_OFF
);
    psd_pkg::psd_state_t s_reg;
    psd_pkg::psd_state_t s_next;
    // ----------------------------------------
    // debounce step
    // ----------------------------------------
    // high once the count has run out, or at once when debounce is off
    function automatic logic deb_done(input logic db_en, input logic [`PSD_CNT_W-1:0] cnt,
                                      input int unsigned lim);
        deb_done = !db_en || ({8'h00, cnt} >= (lim - 32'h1));
    endfunction : deb_done
    logic [`PSD_ADC_W-1:0] thr_sel;
    logic rm_raw;
    logic [31:0] rd;
    logic rd_ok;
    logic acc;
    logic wr;
    logic usb_done;
    logic adp_done;
    logic bat_done;
    logic sys_done;
    logic [3:0] ev;
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        ev = 4'h0;
        // two-flop synchronisers; first stage read only by the second
        s_next.sy_id = {s_reg.sy_id[0], I_ID_HIGH};
        s_next.sy_vbat = {s_reg.sy_vbat[0], I_VBAT_OK};
        s_next.sy_sys = {s_reg.sy_sys[0], I_SYS_OK};
        s_next.sy_usb = {s_reg.sy_usb[0], I_USB_OK};
        s_next.sy_adp = {s_reg.sy_adp[0], I_ADP_OK};
        s_next.sy_lnk = {s_reg.sy_lnk[0], I_LINK_LINE_IN};
        s_next.sy_host = {s_reg.sy_host[0], I_LINK_FROM_HOST};
        // otp defaults loaded once after reset release
        if (!s_reg.thr_loaded) begin
            s_next.thr_bat = I_OTP_THR_BAT; // R21
            s_next.thr_sdp = I_OTP_THR_SDP;
            s_next.thr_dcp = I_OTP_THR_DCP;
            s_next.thr_dc = I_OTP_THR_DC;
            s_next.thr_loaded = 1'b1;
        end
        // presence: identity line high is removal, voltage low is removal
        if (s_reg.ctrl[`PSD_C_RMSRC]) begin
            rm_raw = s_reg.sy_id[1]; // R1 R23
        end else begin
            rm_raw = !s_reg.sy_vbat[1]; // R23
        end
        // link mode freezes the last presence sample
        if (s_reg.ctrl[`PSD_C_DBL]) begin
            rm_raw = s_reg.id_hold; // R4 R5
        end else begin
            s_next.id_hold = rm_raw;
        end
        bat_done = deb_done(1'b1, s_reg.cnt_bat, DEB_CYC);
        if ((!rm_raw) == s_reg.st[`PSD_S_BAT]) begin
            s_next.cnt_bat = '0; // R24
        end else if (bat_done) begin
            s_next.cnt_bat = '0;
            s_next.st[`PSD_S_BAT] = !rm_raw; // R2
            ev[`PSD_I_BAT] = 1'b1;
        end else begin
            s_next.cnt_bat = s_reg.cnt_bat + 1'b1;
        end
        // system rail: only rising is debounced, falling drops at once
        sys_done = deb_done(1'b1, s_reg.cnt_sys, DEB_CYC);
        if (!s_reg.sy_sys[1]) begin
            s_next.cnt_sys = '0; // R24
            s_next.st[`PSD_S_SYS] = 1'b0;
        end else if (!s_reg.st[`PSD_S_SYS]) begin
            if (sys_done) begin
                s_next.st[`PSD_S_SYS] = 1'b1; // R8
                ev[`PSD_I_SYS] = 1'b1;
            end else begin
                s_next.cnt_sys = s_reg.cnt_sys + 1'b1;
            end
        end
        usb_done = deb_done(s_reg.ctrl[`PSD_C_USBDB], s_reg.cnt_usb, DEB_CYC);
        if (s_reg.sy_usb[1] == s_reg.st[`PSD_S_USB]) begin
            s_next.cnt_usb = '0; // R24
        end else if (usb_done) begin
            s_next.cnt_usb = '0;
            s_next.st[`PSD_S_USB] = s_reg.sy_usb[1]; // R9 R10 R11 R12
            ev[`PSD_I_USB] = 1'b1; // R13
        end else begin
            s_next.cnt_usb = s_reg.cnt_usb + 1'b1;
        end
        adp_done = deb_done(s_reg.ctrl[`PSD_C_ADPDB], s_reg.cnt_adp, DEB_CYC);
        if (s_reg.sy_adp[1] == s_reg.st[`PSD_S_ADP]) begin
            s_next.cnt_adp = '0; // R24
        end else if (adp_done) begin
            s_next.cnt_adp = '0;
            s_next.st[`PSD_S_ADP] = s_reg.sy_adp[1]; // R15 R16
            ev[`PSD_I_ADP] = 1'b1; // R17
        end else begin
            s_next.cnt_adp = s_reg.cnt_adp + 1'b1;
        end
        // cold off latches on confirmed removal when so configured
        if (ev[`PSD_I_BAT] && rm_raw && s_reg.ctrl[`PSD_C_RMEN] && s_reg.ctrl[`PSD_C_COLD]) begin
            s_next.cold = 1'b1; // R3
        end
        // only removals are gated by the enable; insertions always flag
        if (!s_reg.ctrl[`PSD_C_RMEN] && !s_next.st[`PSD_S_BAT]) begin
            ev[`PSD_I_BAT] = 1'b0; // R1
        end
        // threshold by source, adapter first
        if (s_reg.st[`PSD_S_ADP]) begin
            thr_sel = s_reg.thr_dc; // R19
        end else if (s_reg.st[`PSD_S_USB] && s_reg.ctrl[`PSD_C_DCP]) begin
            thr_sel = s_reg.thr_dcp;
        end else if (s_reg.st[`PSD_S_USB]) begin
            thr_sel = s_reg.thr_sdp;
        end else begin
            thr_sel = s_reg.thr_bat;
        end
        // measurement: after each detection event, repeat while on external power
        s_next.adc_start = 1'b0;
        case (s_reg.adc_st)
            psd_pkg::PSD_ADC_IDLE: begin
                if (ev != 4'h0 || s_reg.st[`PSD_S_USB] || s_reg.st[`PSD_S_ADP]) begin
                    s_next.adc_st = psd_pkg::PSD_ADC_REQ; // R18 R20
                end
            end
            psd_pkg::PSD_ADC_REQ: begin
                s_next.adc_start = 1'b1;
                s_next.adc_st = psd_pkg::PSD_ADC_WAIT;
            end
            psd_pkg::PSD_ADC_WAIT: begin
                if (I_ADC_DONE) begin
                    s_next.adc_last = I_ADC_DATA;
                    s_next.low = (I_ADC_DATA < thr_sel); // R18 R20
                    s_next.adc_st = psd_pkg::PSD_ADC_IDLE;
                end
            end
            default: begin
                s_next.adc_st = psd_pkg::PSD_ADC_IDLE;
            end
        endcase
        // link pass-through, only while link mode is on
        s_next.link_oe = s_reg.ctrl[`PSD_C_DBL] && !s_reg.sy_host[1]; // R6
        s_next.link_host = s_reg.ctrl[`PSD_C_DBL] ? s_reg.sy_lnk[1] : 1'b1; // R6
        // apb
        acc = I_PSEL && I_PENABLE && !s_reg.pready;
        // write lands at the edge where the master sees pready high
        wr = I_PSEL && I_PENABLE && I_PWRITE && s_reg.pready;
        rd = 32'h0;
        rd_ok = 1'b1;
        if (I_PADDR == `PSD_OFF_CTRL) begin
            rd = {25'h0, s_reg.ctrl};
        end else if (I_PADDR == `PSD_OFF_STAT) begin
            rd = {27'h0, s_reg.low, s_reg.st}; // R14
        end else if (I_PADDR == `PSD_OFF_IRQ2) begin
            rd = {28'h0, s_reg.flags};
        end else if (I_PADDR == `PSD_OFF_IRQ1) begin
            rd = {31'h0, s_reg.src_flag};
        end else if (I_PADDR == `PSD_OFF_THR_BAT) begin
            rd = {22'h0, s_reg.thr_bat};
        end else if (I_PADDR == `PSD_OFF_THR_SDP) begin
            rd = {22'h0, s_reg.thr_sdp};
        end else if (I_PADDR == `PSD_OFF_THR_DCP) begin
            rd = {22'h0, s_reg.thr_dcp};
        end else if (I_PADDR == `PSD_OFF_THR_DC) begin
            rd = {22'h0, s_reg.thr_dc};
        end else if (I_PADDR == `PSD_OFF_ADC) begin
            rd = {22'h0, s_reg.adc_last};
        end else begin
            rd_ok = 1'b0;
        end
        s_next.pready = acc;
        s_next.pslverr = acc && !rd_ok;
        s_next.prdata = (acc && !I_PWRITE) ? rd : 32'h0;
        if (wr && rd_ok) begin
            if (I_PADDR == `PSD_OFF_CTRL) begin
                s_next.ctrl = I_PWDATA[6:0]; // R7
            end else if (I_PADDR == `PSD_OFF_IRQ2) begin
                s_next.flags = s_reg.flags & ~I_PWDATA[3:0];
            end else if (I_PADDR == `PSD_OFF_THR_BAT) begin
                s_next.thr_bat = I_PWDATA[`PSD_ADC_W-1:0]; // R21
            end else if (I_PADDR == `PSD_OFF_THR_SDP) begin
                s_next.thr_sdp = I_PWDATA[`PSD_ADC_W-1:0];
            end else if (I_PADDR == `PSD_OFF_THR_DCP) begin
                s_next.thr_dcp = I_PWDATA[`PSD_ADC_W-1:0];
            end else if (I_PADDR == `PSD_OFF_THR_DC) begin
                s_next.thr_dc = I_PWDATA[`PSD_ADC_W-1:0];
            end
        end
        // set wins over the write-one clear
        s_next.flags = s_next.flags | ev; // R13 R17 R22
        s_next.src_flag = |s_next.flags; // R13 R17
        s_next.irq = s_next.src_flag; // R22
    end
    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            s_reg <= '0;
            s_reg.ctrl <= `PSD_CTRL_RST;
            s_reg.link_host <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
    assign O_PRDATA = s_reg.prdata;
    assign O_PREADY = s_reg.pready;
    assign O_PSLVERR = s_reg.pslverr;
    assign O_ADC_START = s_reg.adc_start;
    assign O_LINK_LINE_OE = s_reg.link_oe;
    assign O_LINK_TO_HOST = s_reg.link_host;
    assign O_SYS_VALID = s_reg.st[`PSD_S_SYS];
    assign O_LOW_BATTERY = s_reg.low;
    assign O_IRQ = s_reg.irq;
    assign O_COLD_OFF = s_reg.cold;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    sequence usb_flip_s;
        s_reg.st[`PSD_S_USB] != $past(s_reg.st[`PSD_S_USB]);
    endsequence
    usb_flag_set_a: assert property (usb_flip_s |-> s_reg.flags[`PSD_I_USB]) // R13
        else $error("usb change without flag");
    adp_flag_set_a: assert property ($changed(s_reg.st[`PSD_S_ADP]) |-> s_reg.flags[`PSD_I_ADP]) // R17
        else $error("adapter change without flag");
    usb_fast_a: assert property (!s_reg.ctrl[`PSD_C_USBDB] && s_reg.sy_usb[1] != s_reg.st[`PSD_S_USB]
        |=> s_reg.st[`PSD_S_USB] == $past(s_reg.sy_usb[1])) // R10 R12
        else $error("usb not immediate");
    usb_deb_a: assert property ((s_reg.ctrl[`PSD_C_USBDB] && $past(s_reg.ctrl[`PSD_C_USBDB])) ##0 usb_flip_s
        |-> $past(s_reg.cnt_usb) != '0) // R9 R11
        else $error("usb changed without debounce");
    sys_deb_a: assert property ($rose(O_SYS_VALID) |-> $past(s_reg.cnt_sys) != '0) // R8
        else $error("rail valid without debounce");
    bounce_rst_a: assert property (s_reg.sy_adp[1] == s_reg.st[`PSD_S_ADP] |=> s_reg.cnt_adp == '0) // R24
        else $error("counter not restarted");
    link_hold_a: assert property (s_reg.ctrl[`PSD_C_DBL] && $past(s_reg.ctrl[`PSD_C_DBL])
        |-> s_reg.id_hold == $past(s_reg.id_hold)) // R5
        else $error("held presence changed");
    irq_level_a: assert property (|s_reg.flags |-> O_IRQ && s_reg.src_flag) // R22
        else $error("flag without interrupt");
    adc_cmp_a: assert property (s_reg.adc_st == psd_pkg::PSD_ADC_WAIT && I_ADC_DONE
        |=> O_LOW_BATTERY == ($past(I_ADC_DATA) < $past(thr_sel))) // R20
        else $error("low pin mismatch");
endmodule : psd_top
`default_nettype wire
